/* rtl/isp_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "isp_defines.vh"

module isp_port #(
  parameter [7:0] SIG0       = 8'h12,
  parameter [7:0] SIG1       = 8'h34,
  parameter [7:0] SIG2       = 8'h56,
  parameter [7:0] CAL_BYTE   = 8'h80,
  parameter       FIFO_DEPTH = 16,
  parameter       FIFO_AW    = 4
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        reset_pin_n,
  input  wire        sck,
  input  wire        mosi,
  output reg         miso,
  output reg         miso_oe_n,
  output wire        cmd_valid,
  input  wire        cmd_ready,
  output wire [2:0]  cmd_op,
  output wire [14:0] cmd_addr,
  output wire [7:0]  cmd_data,
  input  wire        mem_busy,
  output reg         rd_req,
  output reg  [1:0]  rd_space,
  output reg  [14:0] rd_addr,
  input  wire [7:0]  rd_data,
  input  wire        rd_valid,
  output reg         prog_mode,
  output reg  [7:0]  lock_bits,
  output reg  [7:0]  fuse_low,
  output reg  [7:0]  fuse_high,
  output reg         cmd_overrun
);

  // --------------------------------------------------------------------
  // pin synchronisers and edge detection
  // --------------------------------------------------------------------
  reg  [1:0]  sck_s_q;
  reg  [1:0]  mosi_s_q;
  reg  [1:0]  rstn_s_q;
  reg         sck_d1_q;

  // first stages feed only the second stages
  always @(posedge clock) begin
    if (sys_rst) begin
      sck_s_q  <= 2'h0;
      mosi_s_q <= 2'h0;
      rstn_s_q <= 2'h3;
      sck_d1_q <= 1'b0;
    end else begin
      sck_s_q  <= {sck_s_q[0], sck};
      mosi_s_q <= {mosi_s_q[0], mosi};
      rstn_s_q <= {rstn_s_q[0], reset_pin_n};
      sck_d1_q <= sck_s_q[1];
    end
  end

  wire active = ~rstn_s_q[1];
  wire rise   = active & sck_s_q[1] & ~sck_d1_q;
  wire fall   = active & ~sck_s_q[1] & sck_d1_q;

  // --------------------------------------------------------------------
  // shift register and field views
  // --------------------------------------------------------------------
  reg  [31:0] sr_q;
  reg  [4:0]  cnt_q;
  reg  [7:0]  obuf_q;
  reg  [7:0]  resp_q;
  reg         ff_force_q;
  reg         rd_wait_q;

  wire [31:0] sr_n     = {sr_q[30:0], mosi_s_q[1]};
  wire        byte_end = rise & (cnt_q[2:0] == 3'h7);
  wire        end3     = rise & (cnt_q == 5'd23);
  wire        end4     = rise & (cnt_q == 5'd31);

  // view after byte three, used to start reads early
  wire [7:0]  e_b0 = sr_n[23:16];
  wire [7:0]  e_b1 = sr_n[15:8];
  wire [7:0]  e_b2 = sr_n[7:0];
  // view after byte four, used to act on whole instructions
  wire [7:0]  f_b0 = sr_n[31:24];
  wire [7:0]  f_b1 = sr_n[23:16];
  wire [7:0]  f_b2 = sr_n[15:8];
  wire [7:0]  f_b3 = sr_n[7:0];

  // --------------------------------------------------------------------
  // write-in-progress tracking
  // --------------------------------------------------------------------
  reg         pend_q;
  reg  [25:0] pend_word_q;
  reg         fl_wip_q;
  reg         er_wip_q;
  reg         ee_wip_q;
  reg  [7:0]  fl_page_q;
  reg  [9:0]  ee_addr_q;
  wire        fifo_in_ready;
  wire        wip = pend_q | cmd_valid | mem_busy;

  // --------------------------------------------------------------------
  // whole-instruction decode
  // --------------------------------------------------------------------
  wire is_enable = (f_b0 == `ISP_PFX_ENABLE) && (f_b1 == `ISP_B2_ENABLE);
  wire is_erase  = (f_b0 == `ISP_PFX_ENABLE) && (f_b1[7:5] == `ISP_B2_ERASE_TOP);
  wire is_lockwr = (f_b0 == `ISP_PFX_ENABLE) && (f_b1[7:5] == `ISP_B2_LOCK_TOP);
  wire is_fuselo = (f_b0 == `ISP_PFX_ENABLE) && (f_b1 == `ISP_B2_FUSE_LO);
  wire is_fusehi = (f_b0 == `ISP_PFX_ENABLE) && (f_b1 == `ISP_B2_FUSE_HI);
  wire is_load   = ((f_b0 & `ISP_HBIT_MASK) == `ISP_OP_LD_PAGE) && (f_b0 != `ISP_OP_WR_PAGE);
  wire is_page   = (f_b0 == `ISP_OP_WR_PAGE);
  wire is_eewr   = (f_b0 == `ISP_OP_WR_EE);

  reg         push;
  reg  [25:0] push_word;

  // build the command word for the memory back end
  always @* begin
    push      = 1'b0;
    push_word = 26'h0;
    if (end4 && prog_mode) begin
      if (is_erase) begin
        push      = 1'b1;
        push_word = {`ISP_CMD_ERASE, 15'h0, 8'h0};
      end else if (is_load) begin
        push      = 1'b1;
        push_word = {`ISP_CMD_LOAD, 8'h0, f_b2[5:0], f_b0[`ISP_HBIT_POS], f_b3};
      end else if (is_page) begin
        push      = 1'b1;
        push_word = {`ISP_CMD_PAGE, 7'h0, f_b1[5:0], f_b2[7:6], 8'h0};
      end else if (is_eewr) begin
        push      = 1'b1;
        push_word = {`ISP_CMD_EEWR, 5'h0, f_b1[1:0], f_b2, f_b3};
      end
    end
  end

  // --------------------------------------------------------------------
  // serial framing, mode and local bytes
  // --------------------------------------------------------------------
  // reset pin high drops the mode and realigns the frame
  always @(posedge clock) begin
    if (sys_rst || !active) begin
      sr_q      <= 32'h0;
      cnt_q     <= 5'h0;
      obuf_q    <= 8'h0;
      prog_mode <= 1'b0;
    end else begin
      if (rise) begin
        sr_q  <= sr_n;
        cnt_q <= cnt_q + 5'h1;
      end
      if (byte_end) begin
        obuf_q <= sr_n[7:0];
      end
      if (end4 && is_enable) begin
        prog_mode <= 1'b1;
      end
    end
  end

  // lock and fuse bytes persist over pin resets
  always @(posedge clock) begin
    if (sys_rst) begin
      lock_bits <= `ISP_ERASED_BYTE;
      fuse_low  <= `ISP_FUSE_LO_RST;
      fuse_high <= `ISP_FUSE_HI_RST;
    end else if (end4 && prog_mode) begin
      if (is_erase) begin
        lock_bits <= `ISP_ERASED_BYTE;
      end else if (is_lockwr) begin
        lock_bits <= lock_bits & (f_b3 | `ISP_LOCK_FIXED);
      end
      if (is_fuselo) begin
        fuse_low <= f_b3;
      end
      if (is_fusehi) begin
        fuse_high <= f_b3;
      end
    end
  end

  // --------------------------------------------------------------------
  // read path: request after byte three, answer in byte four
  // --------------------------------------------------------------------
  wire        rd_fl   = (e_b0 & `ISP_HBIT_MASK) == `ISP_OP_RD_FLASH;
  wire        rd_ee   = (e_b0 == `ISP_OP_RD_EE);
  wire [13:0] fl_word = {e_b1[5:0], e_b2};
  wire [9:0]  ee_word = {e_b1[1:0], e_b2};
  wire        fl_hit  = wip & (er_wip_q | (fl_wip_q & (fl_word[13:6] == fl_page_q)));
  wire        ee_hit  = wip & (er_wip_q | (ee_wip_q & (ee_word == ee_addr_q)));

  // local bytes answer at once; arrays answer on rd_valid
  always @(posedge clock) begin
    if (sys_rst) begin
      rd_req     <= 1'b0;
      rd_space   <= `ISP_SPACE_FLASH;
      rd_addr    <= 15'h0;
      resp_q     <= 8'h0;
      ff_force_q <= 1'b0;
      rd_wait_q  <= 1'b0;
    end else begin
      rd_req <= 1'b0;
      if (end3) begin
        resp_q <= e_b2;
        if (prog_mode && rd_fl) begin
          rd_req     <= 1'b1;
          rd_space   <= `ISP_SPACE_FLASH;
          rd_addr    <= {fl_word, e_b0[`ISP_HBIT_POS]};
          ff_force_q <= fl_hit;
          rd_wait_q  <= 1'b1;
        end else if (prog_mode && rd_ee) begin
          rd_req     <= 1'b1;
          rd_space   <= `ISP_SPACE_EE;
          rd_addr    <= {5'h0, ee_word};
          ff_force_q <= ee_hit;
          rd_wait_q  <= 1'b1;
        end else if (prog_mode && e_b0 == `ISP_OP_RD_LOCK && e_b1 == 8'h00) begin
          resp_q <= lock_bits;
        end else if (prog_mode && e_b0 == `ISP_OP_RD_LOCK && e_b1 == `ISP_B2_RD_FUSE_HI) begin
          resp_q <= fuse_high;
        end else if (prog_mode && e_b0 == `ISP_OP_RD_FUSE_LO && e_b1 == 8'h00) begin
          resp_q <= fuse_low;
        end else if (prog_mode && e_b0 == `ISP_OP_RD_SIG) begin
          case (e_b2[1:0])
            2'h0:    resp_q <= SIG0;
            2'h1:    resp_q <= SIG1;
            2'h2:    resp_q <= SIG2;
            default: resp_q <= `ISP_ERASED_BYTE;
          endcase
        end else if (prog_mode && e_b0 == `ISP_OP_RD_CAL) begin
          resp_q <= CAL_BYTE;
        end
      end else if (rd_wait_q && rd_valid) begin
        resp_q    <= ff_force_q ? `ISP_ERASED_BYTE : rd_data;
        rd_wait_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // serial output
  // --------------------------------------------------------------------
  wire [2:0] bit_sel = 3'h7 - cnt_q[2:0];

  // byte four carries the answer, other bytes echo the last byte in
  always @(posedge clock) begin
    if (sys_rst) begin
      miso      <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= ~active;
      if (fall) begin
        miso <= (cnt_q[4:3] == 2'h3) ? resp_q[bit_sel] : obuf_q[bit_sel];
      end
    end
  end

  // --------------------------------------------------------------------
  // pending push, overrun and busy flags
  // --------------------------------------------------------------------
  // one-deep holding stage absorbs fifo back-pressure; a second write
  // arriving while it is still held is lost and flagged
  always @(posedge clock) begin
    if (sys_rst) begin
      pend_q      <= 1'b0;
      pend_word_q <= 26'h0;
      cmd_overrun <= 1'b0;
    end else begin
      if (push && pend_q && !fifo_in_ready) begin
        cmd_overrun <= 1'b1;
      end else if (!active) begin
        cmd_overrun <= 1'b0;
      end
      if (push && (!pend_q || fifo_in_ready)) begin
        pend_q      <= 1'b1;
        pend_word_q <= push_word;
      end else if (fifo_in_ready) begin
        pend_q <= 1'b0;
      end
    end
  end

  // a new write sets its flag even as the old one clears
  always @(posedge clock) begin
    if (sys_rst) begin
      fl_wip_q  <= 1'b0;
      er_wip_q  <= 1'b0;
      ee_wip_q  <= 1'b0;
      fl_page_q <= 8'h0;
      ee_addr_q <= 10'h0;
    end else begin
      if (!wip) begin
        fl_wip_q <= 1'b0;
        er_wip_q <= 1'b0;
        ee_wip_q <= 1'b0;
      end
      if (push && is_page) begin
        fl_wip_q  <= 1'b1;
        fl_page_q <= {f_b1[5:0], f_b2[7:6]};
      end
      if (push && is_erase) begin
        er_wip_q <= 1'b1;
      end
      if (push && is_eewr) begin
        ee_wip_q  <= 1'b1;
        ee_addr_q <= {f_b1[1:0], f_b2};
      end
    end
  end

  // --------------------------------------------------------------------
  // command fifo toward the memory back end
  // --------------------------------------------------------------------
  wire [25:0] fifo_out;

  isp_cmd_fifo #(
    .WIDTH (`ISP_CMD_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (pend_q),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_word_q),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (fifo_out)
  );

  assign cmd_op   = fifo_out[25:23];
  assign cmd_addr = fifo_out[22:8];
  assign cmd_data = fifo_out[7:0];

endmodule

`default_nettype wire

/* rtl/isp_defines.vh */
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH

// ----------------------------------------------------------------------
// instruction framing
// ----------------------------------------------------------------------
`define ISP_FRAME_BITS     32
`define ISP_BYTE_BITS      8

// ----------------------------------------------------------------------
// first-byte and second-byte patterns
// ----------------------------------------------------------------------
`define ISP_PFX_ENABLE     8'hAC
`define ISP_B2_ENABLE      8'h53
`define ISP_B2_ERASE_TOP   3'h4
`define ISP_B2_LOCK_TOP    3'h7
`define ISP_B2_FUSE_LO     8'hA0
`define ISP_B2_FUSE_HI     8'hA8
`define ISP_OP_RD_FLASH    8'h20
`define ISP_OP_LD_PAGE     8'h40
`define ISP_OP_WR_PAGE     8'h4C
`define ISP_OP_RD_EE       8'hA0
`define ISP_OP_WR_EE       8'hC0
`define ISP_OP_RD_LOCK     8'h58
`define ISP_OP_RD_FUSE_LO  8'h50
`define ISP_B2_RD_FUSE_HI  8'h08
`define ISP_OP_RD_SIG      8'h30
`define ISP_OP_RD_CAL      8'h38
`define ISP_HBIT_POS       3
`define ISP_HBIT_MASK      8'hF7

// ----------------------------------------------------------------------
// command word toward the memory back end
// ----------------------------------------------------------------------
`define ISP_CMD_ERASE      3'h1
`define ISP_CMD_LOAD       3'h2
`define ISP_CMD_PAGE       3'h3
`define ISP_CMD_EEWR       3'h4
`define ISP_SPACE_FLASH    2'h0
`define ISP_SPACE_EE       2'h1
`define ISP_CMD_WIDTH      26

// ----------------------------------------------------------------------
// reset values of locally held bytes, and the fixed lock bits
// ----------------------------------------------------------------------
`define ISP_ERASED_BYTE    8'hFF
`define ISP_LOCK_FIXED     8'hC0
`define ISP_FUSE_LO_RST    8'hFF
`define ISP_FUSE_HI_RST    8'hFF

// ----------------------------------------------------------------------
// programmer-side minimum waits, for reference
// ----------------------------------------------------------------------
`define ISP_T_WD_FLASH_US  4500
`define ISP_T_WD_EE_US     9000
`define ISP_T_WD_FUSE_US   4500
`define ISP_T_WD_ERASE_US  9000

`endif

/* rtl/isp_cmd_fifo.v */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// command fifo, flip-flop storage
// ----------------------------------------------------------------------
module isp_cmd_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clock,
  input  wire             sys_rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;

  // extra pointer bit tells full from empty
  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];

  // pointers
  always @(posedge clock) begin
    if (sys_rst) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // storage needs no reset, never read while empty
  always @(posedge clock) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

endmodule

`default_nettype wire

/* rtl/README_unused.v */
`timescale 1ns/1ps

/* dv/isp_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// port checker
// ------------------------------------------
module isp_port_chk (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        reset_pin_n,
  input wire logic        sck,
  input wire logic        miso,
  input wire logic        miso_oe_n,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [2:0]  cmd_op,
  input wire logic [14:0] cmd_addr,
  input wire logic [7:0]  cmd_data,
  input wire logic        rd_req,
  input wire logic        prog_mode,
  input wire logic [7:0]  lock_bits,
  input wire logic        cmd_overrun
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // serial side: sck seen low two samples before any miso move
  a_miso_on_fall: assert property ($changed(miso) |-> !$past(sck, 2))
    else $error("miso moved outside a low sck phase");
  a_oe_idle: assert property (reset_pin_n [*5] |-> miso_oe_n)
    else $error("miso driven while reset pin high");
  a_mode_drops: assert property (reset_pin_n [*5] |-> !prog_mode)
    else $error("programming mode kept with reset pin high");
  a_read_needs_mode: assert property (rd_req |-> prog_mode)
    else $error("read request outside programming mode");
  a_cmd_after_mode: assert property ($rose(cmd_valid) |-> $past(prog_mode, 2))
    else $error("command queued outside programming mode");
  // command queue: head held while stalled, sane codes, overrun only while stalled
  a_head_holds: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_op)
    && $stable(cmd_addr) && $stable(cmd_data))
    else $error("command head changed while stalled");
  a_op_known: assert property (cmd_valid |-> cmd_op inside {3'h1, 3'h2, 3'h3, 3'h4})
    else $error("unknown command code");
  a_overrun_cause: assert property ($rose(cmd_overrun) |-> $past(cmd_valid && !cmd_ready))
    else $error("overrun without a stalled queue");
  a_overrun_sticky: assert property (cmd_overrun && !reset_pin_n |=> cmd_overrun)
    else $error("overrun flag dropped");
  a_lock_top: assert property (lock_bits[7:6] == 2'b11)
    else $error("fixed lock bits not ones");
  c_enable: cover property ($rose(prog_mode));
  c_read: cover property (rd_req);
  c_pop: cover property (cmd_valid && cmd_ready);
  c_overrun: cover property ($rose(cmd_overrun));
endmodule

bind isp_port isp_port_chk isp_port_chk_i (
  .clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .sck(sck),
  .miso(miso), .miso_oe_n(miso_oe_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_req(rd_req),
  .prog_mode(prog_mode), .lock_bits(lock_bits), .cmd_overrun(cmd_overrun)
);
`default_nettype wire

/* dv/isp_programmer.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// external programmer on the serial link
// ------------------------------------------
module isp_programmer #(
  parameter HALF_NS = 200,
  parameter PWR_NS  = 2000,
  parameter WAIT_NS = 1000
) (
  output logic      reset_pin_n,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe_n
);
  // power up with reset pin and sck low
  initial begin
    reset_pin_n = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // one frame, msb first; sck stands low between frames
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
    #13;
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #(HALF_NS) sck = 1'b1;
      resp[i] = miso_oe_n ? 1'bz : miso;
      #(HALF_NS) sck = 1'b0;
    end
    mosi = ~mosi;
    #(HALF_NS);
  endtask
  // enable; a missing echo costs a reset pulse and one retry
  task automatic enable(output logic [7:0] echo);
    logic [31:0] r;
    #(PWR_NS);
    for (int n = 0; n < 2; n++) begin
      xfer(32'hAC53_0000, r);
      echo = r[15:8];
      if (echo === 8'h53)
        break;
      reset_pin_n = 1'b1;
      #(HALF_NS) reset_pin_n = 1'b0;
      #(HALF_NS);
    end
  endtask
  // shortened stand-in for the minimum waits when not polling
  task automatic wait_write;
    #(WAIT_NS);
  endtask
  task automatic release_pin;
    reset_pin_n = 1'b1;
    #(HALF_NS * 2);
  endtask
endmodule
`default_nettype wire

/* dv/serial_nvm_programming_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin n_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
// ------------------------------------------
// bench top
// ------------------------------------------
module serial_nvm_programming_port_test;
  localparam logic [7:0] SIG_A = 8'h21; // arbitrary identity value
  localparam logic [7:0] SIG_B = 8'h43; // arbitrary identity value
  localparam logic [7:0] SIG_C = 8'h65; // arbitrary identity value
  localparam logic [7:0] CAL   = 8'hA7;
  logic        clock, sys_rst, reset_pin_n, sck, mosi, miso, miso_oe_n, cmd_valid;
  logic        cmd_ready, mem_busy, rd_req, rd_valid, prog_mode, cmd_overrun;
  logic [2:0]  cmd_op;
  logic [14:0] cmd_addr, rd_addr;
  logic [7:0]  cmd_data, rd_data, lock_bits, fuse_low, fuse_high;
  logic [1:0]  rd_space;
  logic [31:0] r;
  logic [25:0] popped[$];
  int          n_errors = 0;
  int          num_checks = 0;

  isp_port #(.SIG0(SIG_A), .SIG1(SIG_B), .SIG2(SIG_C), .CAL_BYTE(CAL)) isp_port_i (
    .clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .mem_busy(mem_busy),
    .rd_req(rd_req), .rd_space(rd_space), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .prog_mode(prog_mode), .lock_bits(lock_bits),
    .fuse_low(fuse_low), .fuse_high(fuse_high), .cmd_overrun(cmd_overrun));
  isp_programmer isp_programmer_i (.reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n));

  // memory back end: read answer one cycle after request, pops logged
  function automatic logic [7:0] mem_byte(input logic [1:0] sp, input logic [14:0] a);
    return {a[6:0], sp[0]} ^ 8'h5A;
  endfunction
  always @(posedge clock) begin
    rd_valid <= rd_req;
    rd_data <= mem_byte(rd_space, rd_addr);
    if (cmd_valid === 1'b1 && cmd_ready)
      popped.push_back({cmd_op, cmd_addr, cmd_data});
  end
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // frame plus a short settle so queue and read paths have landed
  task automatic send(input logic [31:0] c);
    isp_programmer_i.xfer(c, r);
    repeat (6) @(posedge clock);
  endtask
  task automatic t_enable;
    logic [7:0] echo;
    repeat (8) @(posedge clock);
    send(32'hACE0_0000);
    `CHK("lock_bits", 8'hFF, lock_bits)
    isp_programmer_i.enable(echo);
    repeat (4) @(posedge clock);
    `CHK("echo", 8'h53, echo)
    `CHK("prog_mode", 1'b1, prog_mode)
    $display("t_enable done");
  endtask
  task automatic t_local;
    // signature index rides in the low bits of byte three, not byte four
    logic [31:0] c[8] = '{32'h5800_0000, 32'h5000_0000, 32'h5808_0000, 32'h3000_0000,
                          32'h3000_0100, 32'h3000_0200, 32'h3800_0000, 32'h3000_0300};
    logic [7:0]  e[8] = '{8'hF3, 8'h5A, 8'h3C, SIG_A, SIG_B, SIG_C, CAL, 8'hFF};
    send(32'hACE0_00F3);
    send(32'hACA0_005A);
    isp_programmer_i.wait_write;
    send(32'hACA8_003C);
    isp_programmer_i.wait_write;
    `CHK("lock_bits", 8'hF3, lock_bits)
    `CHK("fuse_low", 8'h5A, fuse_low)
    `CHK("fuse_high", 8'h3C, fuse_high)
    for (int i = 0; i < 8; i++) begin
      send(c[i]);
      `CHK("local read", e[i], r[7:0])
    end
    $display("t_local done");
  endtask
  task automatic t_cmds;
    logic [31:0] c[4] = '{32'h4000_05AB, 32'h4800_05CD, 32'h4C01_8000, 32'hC001_2377};
    logic [25:0] e[4] = '{{3'h2, 15'h000A, 8'hAB}, {3'h2, 15'h000B, 8'hCD},
                          {3'h3, 15'h0006, 8'h00}, {3'h4, 15'h0123, 8'h77}};
    popped.delete();
    for (int i = 0; i < 4; i++)
      send(c[i]);
    send(32'hAC80_0000);
    isp_programmer_i.wait_write;
    `CHK("pops", 5, popped.size())
    for (int i = 0; i < 4; i++)
      `CHK("cmd word", e[i], popped[i])
    `CHK("erase op", 3'h1, popped[4][25:23])
    `CHK("lock after erase", 8'hFF, lock_bits)
    $display("t_cmds done");
  endtask
  task automatic t_reads;
    logic [31:0] c[3] = '{32'h2012_3400, 32'h2812_3400, 32'hA001_2300};
    logic [16:0] e[3] = '{{2'h0, 15'h2468}, {2'h0, 15'h2469}, {2'h1, 15'h0123}};
    for (int i = 0; i < 3; i++) begin
      send(c[i]);
      `CHK("rd_space", e[i][16:15], rd_space)
      `CHK("rd_addr", e[i][14:0], rd_addr)
      `CHK("read data", mem_byte(e[i][16:15], e[i][14:0]), r[7:0])
    end
    $display("t_reads done");
  endtask
  // reads of a page or address still being written answer 0xFF while the back end is busy
  task automatic t_poll;
    @(posedge clock) mem_busy <= 1'b1;
    send(32'h4C00_4000);
    send(32'h2000_4100);
    `CHK("flash poll", 8'hFF, r[7:0])
    send(32'h2000_8100);
    `CHK("other page", mem_byte(2'h0, 15'h0102), r[7:0])
    @(posedge clock) mem_busy <= 1'b0;
    send(32'h2000_4100);
    `CHK("flash done", mem_byte(2'h0, 15'h0082), r[7:0])
    @(posedge clock) mem_busy <= 1'b1;
    send(32'hC000_1099);
    send(32'hA000_1000);
    `CHK("eeprom poll", 8'hFF, r[7:0])
    @(posedge clock) mem_busy <= 1'b0;
    send(32'hA000_1000);
    `CHK("eeprom done", mem_byte(2'h1, 15'h0010), r[7:0])
    $display("t_poll done");
  endtask
  // back end stalls: sixteen queued, one held, the next one lost
  task automatic t_fifo;
    @(posedge clock) cmd_ready <= 1'b0;
    popped.delete();
    for (int i = 0; i < 18; i++) begin
      send({16'hC000, i[7:0], i[7:0]});
      if (i == 16)
        `CHK("early overrun", 1'b0, cmd_overrun)
    end
    `CHK("overrun", 1'b1, cmd_overrun)
    @(posedge clock) cmd_ready <= 1'b1;
    repeat (40) @(posedge clock);
    `CHK("drained", 17, popped.size())
    `CHK("last word", {3'h4, 15'h0010, 8'h10}, popped[16])
    `CHK("empty", 1'b0, cmd_valid)
    $display("t_fifo done");
  endtask
  task automatic t_release;
    isp_programmer_i.release_pin;
    `CHK("prog_mode", 1'b0, prog_mode)
    `CHK("overrun cleared", 1'b0, cmd_overrun)
    `CHK("fuse kept", 8'h5A, fuse_low)
    `CHK("oe released", 1'b1, miso_oe_n)
    $display("t_release done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    sys_rst = 1'b1;
    cmd_ready = 1'b1;
    mem_busy = 1'b0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_enable;
    t_local;
    t_cmds;
    t_reads;
    t_poll;
    t_fifo;
    t_release;
    end_sim;
  end
  // watchdog: the run needs well under a millisecond
  initial begin
    #2_000_000;
    n_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_sim;
  end
endmodule
`default_nettype wire
